// file: verilog/ignition_mode_override_control.sv
/*
  Crank/run mode, cylinder-one location, dwell selection, spark polarity
  and host override control, configured over APB.
  Assumes APB signals and all pins synchronous to clock.
*/
// Behaviour
// - Crank changes to run when speed reaches transition speed.
// - Run returns to crank when speed falls to transition minus hysteresis.
// - Hysteresis band keeps brief speed swings from toggling the mode.
// - Cylinder one pulse is shorter than normal by the signature angle.
// - Normal pulse spans 360 degrees divided by cylinder count.
// - Cylinder count, filters, signature, speed and hysteresis are settable.
// - Ignition type selects standard, dwell-controlled or distributorless.
// - Dwell angle applies only with standard ignition.
// - Dwell time in microseconds applies only with dwell-controlled type.
// - Level setting inverts the spark output while overriding (host spark passes uninverted); rising edge is standard.
// - Module type selects extender or stand-alone operation.
// - Always-override type overrides the host under all conditions.
// - Speed-only override uses engine speed and ignores throttle setting.
// - Throttle-only override uses throttle and ignores speed setting.
// - Combined override needs speed and throttle both above set points.
`timescale 1ns/10ps
`include "ign_cfg.svh"

module ignition_mode_override_control
  import ign_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic camPositionPulse,
  input wire logic [7:0] throttleAngle,
  input wire logic sparkTiming,
  input wire logic hostSpark,
  input wire logic hostDwell,
  output logic sparkOut,
  output logic dwellOut,
  output logic overrideActive,
  output logic runMode,
  output logic cylOneSync,
  output logic [15:0] dwellValue,
  output logic dwellIsTime
);
  // ==========================================================
  // Configuration registers
  logic [3:0] cyl_ff;
  logic edgeSel_ff;
  logic [15:0] tFilt_ff;
  logic [7:0] sigAng_ff;
  logic [15:0] xSpeed_ff;
  logic [15:0] hyst_ff;
  ignType_t ign_ff;
  logic [7:0] dwAng_ff;
  logic [15:0] dwTime_ff;
  logic standalone_ff;
  ovType_t ovType_ff;
  logic spoutInv_ff;
  logic [15:0] ovSpeed_ff;
  logic [7:0] ovThr_ff;

  // ==========================================================
  // Engine state
  engMode_t mode_ff;
  engMode_t nxt_mode;
  logic override_ff;
  logic nxt_override;
  logic [15:0] rpm_ff;
  logic [15:0] lastIv_ff;
  logic sync_ff;
  logic sparkOut_ff;
  logic dwellOut_ff;
  logic [15:0] dwellVal_ff;
  logic dwellIsTime_ff;
  logic [31:0] rdData_ff;
  logic edgeSeen;
  logic [15:0] interval;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic [15:0] normHalfDeg;
  logic [31:0] shortLimit;
  logic [31:0] rpmCalc;

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a <= `OFF_PERIOD) && (a[1:0] == 2'b00);
  endfunction

  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & ~penable & ~pwrite;
  assign mapped = isMapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdData_ff;

  pulse_timer timer (
    .clock(clock),
    .reset_n(reset_n),
    .pulseIn(camPositionPulse),
    .fallEdge(edgeSel_ff),
    .minTime(tFilt_ff),
    .edgeSeen(edgeSeen),
    .interval(interval)
  );

  // ==========================================================
  // Register writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cyl_ff <= `RST_CYL;
      edgeSel_ff <= `RST_EDGE;
      tFilt_ff <= `RST_TFILT;
      sigAng_ff <= `RST_SIGANG;
      xSpeed_ff <= `RST_XSPEED;
      hyst_ff <= `RST_HYST;
      ign_ff <= IGN_STANDARD;
      dwAng_ff <= `RST_DWANG;
      dwTime_ff <= `RST_DWTIME;
      standalone_ff <= 1'b0;
      ovType_ff <= OV_ALWAYS;
      spoutInv_ff <= 1'b0;
      ovSpeed_ff <= `RST_OVSPEED;
      ovThr_ff <= `RST_OVTHR;
    end else if (wrEn && mapped) begin
      case (paddr)
        `OFF_CYL: cyl_ff <= (pwdata[3:0] == 4'h0) ? 4'h1 : pwdata[3:0];
        `OFF_FILT: begin
          tFilt_ff <= pwdata[15:0];
          edgeSel_ff <= pwdata[`FILT_EDGE_BIT];
        end
        `OFF_SIGANG: sigAng_ff <= pwdata[7:0];
        `OFF_XSPEED: xSpeed_ff <= pwdata[15:0];
        `OFF_HYST: hyst_ff <= pwdata[15:0];
        `OFF_IGN: ign_ff <= ignType_t'(pwdata[1:0]);
        `OFF_DWANG: dwAng_ff <= pwdata[7:0];
        `OFF_DWTIME: dwTime_ff <= pwdata[15:0];
        `OFF_MODCFG: begin
          standalone_ff <= pwdata[`MOD_STANDALONE_BIT];
          ovType_ff <= ovType_t'(pwdata[`MOD_OVTYPE_LO +: 2]);
          spoutInv_ff <= pwdata[`MOD_SPOUT_INV_BIT];
        end
        `OFF_OVSPEED: ovSpeed_ff <= pwdata[15:0];
        `OFF_OVTHR: ovThr_ff <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Register reads, sampled in the setup phase
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdData_ff <= 32'h00000000;
    end else if (rdEn) begin
      case (paddr)
        `OFF_CYL: rdData_ff <= {28'h0000000, cyl_ff};
        `OFF_FILT: rdData_ff <= {15'h0000, edgeSel_ff, tFilt_ff};
        `OFF_SIGANG: rdData_ff <= {24'h000000, sigAng_ff};
        `OFF_XSPEED: rdData_ff <= {16'h0000, xSpeed_ff};
        `OFF_HYST: rdData_ff <= {16'h0000, hyst_ff};
        `OFF_IGN: rdData_ff <= {30'h00000000, ign_ff};
        `OFF_DWANG: rdData_ff <= {24'h000000, dwAng_ff};
        `OFF_DWTIME: rdData_ff <= {16'h0000, dwTime_ff};
        `OFF_MODCFG: rdData_ff <= {28'h0000000, spoutInv_ff, ovType_ff,
                                   standalone_ff};
        `OFF_OVSPEED: rdData_ff <= {16'h0000, ovSpeed_ff};
        `OFF_OVTHR: rdData_ff <= {24'h000000, ovThr_ff};
        `OFF_STATUS: rdData_ff <= {16'h0000, rpm_ff[11:0], sync_ff,
                                   override_ff, 1'b0, mode_ff == MODE_RUN};
        `OFF_PERIOD: rdData_ff <= {16'h0000, lastIv_ff};
        default: rdData_ff <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Engine speed from pulse interval
  // Cylinders/2 pulses per revolution on a 4-stroke distributor
  assign rpmCalc = (interval == 16'h0000) ? 32'hFFFFFFFF :
                   (`US_PER_MIN * 32'd2) / ({16'h0000, interval} * {28'h0, cyl_ff});

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rpm_ff <= 16'h0000;
      lastIv_ff <= 16'h0000;
    end else if (edgeSeen) begin
      rpm_ff <= (rpmCalc > 32'h0000FFFF) ? 16'hFFFF : rpmCalc[15:0];
      lastIv_ff <= interval;
    end else if (interval == 16'hFFFF) begin
      rpm_ff <= 16'h0000;
    end
  end

  // ==========================================================
  // Cylinder one detection: short if interval < last*(norm-sig/2)/norm
  // Angles in half degrees; signature held in half degrees
  assign normHalfDeg = `HALF_DEG_FULL / {12'h000, cyl_ff};
  assign shortLimit = {16'h0000, lastIv_ff} *
                      {16'h0000, normHalfDeg - {8'h00, sigAng_ff} +
                       {8'h00, sigAng_ff[7:1]}};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_ff <= 1'b0;
    end else if (edgeSeen) begin
      sync_ff <= ({16'h0000, interval} * {16'h0000, normHalfDeg}) <
                 shortLimit;
    end else begin
      sync_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Crank/run mode with hysteresis
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_CRANK: if (rpm_ff >= xSpeed_ff) nxt_mode = MODE_RUN;
      MODE_RUN: if ({1'b0, rpm_ff} + {1'b0, hyst_ff} <= {1'b0, xSpeed_ff})
        nxt_mode = MODE_CRANK;
      default: nxt_mode = MODE_CRANK;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= MODE_CRANK;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ==========================================================
  // Override decision
  always_comb begin
    case (ovType_ff)
      OV_ALWAYS: nxt_override = 1'b1;
      OV_SPEED: nxt_override = rpm_ff > ovSpeed_ff;
      OV_THROTTLE: nxt_override = throttleAngle > ovThr_ff;
      OV_BOTH: nxt_override = (rpm_ff > ovSpeed_ff) &&
                              (throttleAngle > ovThr_ff);
      default: nxt_override = 1'b0;
    endcase
    if (standalone_ff) nxt_override = 1'b1;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      override_ff <= 1'b0;
    end else begin
      override_ff <= nxt_override;
    end
  end

  // ==========================================================
  // Dwell selection and outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dwellVal_ff <= 16'h0000;
      dwellIsTime_ff <= 1'b0;
    end else begin
      case (ign_ff)
        IGN_STANDARD: begin
          dwellVal_ff <= {8'h00, dwAng_ff};
          dwellIsTime_ff <= 1'b0;
        end
        IGN_DWELL_CTL: begin
          dwellVal_ff <= dwTime_ff;
          dwellIsTime_ff <= 1'b1;
        end
        default: begin
          dwellVal_ff <= 16'h0000;
          dwellIsTime_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sparkOut_ff <= 1'b0;
      dwellOut_ff <= 1'b0;
    end else if (override_ff) begin
      sparkOut_ff <= sparkTiming ^ spoutInv_ff;
      dwellOut_ff <= sparkTiming;
    end else begin
      sparkOut_ff <= hostSpark;
      dwellOut_ff <= hostDwell;
    end
  end

  assign sparkOut = sparkOut_ff;
  assign dwellOut = dwellOut_ff;
  assign overrideActive = override_ff;
  assign runMode = (mode_ff == MODE_RUN);
  assign cylOneSync = sync_ff;
  assign dwellValue = dwellVal_ff;
  assign dwellIsTime = dwellIsTime_ff;
endmodule

// file: verilog/ign_cfg.svh
/*
  Constants for the ignition mode and override controller: register
  offsets, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef IGN_CFG_SVH
`define IGN_CFG_SVH

// ==========================================================
// Register byte offsets
`define OFF_CYL      12'h000
`define OFF_FILT     12'h004
`define OFF_SIGANG   12'h008
`define OFF_XSPEED   12'h00C
`define OFF_HYST     12'h010
`define OFF_IGN      12'h014
`define OFF_DWANG    12'h018
`define OFF_DWTIME   12'h01C
`define OFF_MODCFG   12'h020
`define OFF_OVSPEED  12'h024
`define OFF_OVTHR    12'h028
`define OFF_STATUS   12'h02C
`define OFF_PERIOD   12'h030

// ==========================================================
// Reset values
`define RST_CYL      4'h8
`define RST_EDGE     1'h0
`define RST_TFILT    16'h0032
`define RST_SIGANG   8'h1B
`define RST_XSPEED   16'h0190
`define RST_HYST     16'h0032
`define RST_IGN      2'h0
`define RST_DWANG    8'h2D
`define RST_DWTIME   16'h1770
`define RST_OVSPEED  16'h0FA0
`define RST_OVTHR    8'h1E

// ==========================================================
// Field positions
`define MOD_STANDALONE_BIT 0
`define MOD_OVTYPE_LO      1
`define MOD_SPOUT_INV_BIT  3
`define FILT_EDGE_BIT      16

// ==========================================================
// Timing: one microsecond tick and rpm from period in us
`define CLK_MHZ        100
`define US_CYCLES      (`CLK_MHZ)
`define US_PER_MIN     32'd60000000
`define HALF_DEG_FULL  16'h02D0

`endif

// file: verilog/ign_pkg.sv
/*
  Types for the ignition mode and override controller.
  Assumes nothing beyond the constants header.
*/
package ign_pkg;
  typedef enum logic [1:0] {
    IGN_STANDARD = 2'h0,
    IGN_DWELL_CTL = 2'h1,
    IGN_DISTLESS = 2'h2
  } ignType_t;

  typedef enum logic [1:0] {
    OV_ALWAYS = 2'h0,
    OV_SPEED = 2'h1,
    OV_THROTTLE = 2'h2,
    OV_BOTH = 2'h3
  } ovType_t;

  typedef enum logic [1:0] {
    MODE_CRANK = 2'b01,
    MODE_RUN = 2'b10
  } engMode_t;
endpackage

// file: verilog/pulse_timer.sv
/*
  Measures the interval between accepted cam position pulse edges in
  microseconds, with edge selection and a minimum-time noise filter.
  Assumes the pulse input is synchronous to clock.
*/
`timescale 1ns/10ps
`include "ign_cfg.svh"

module pulse_timer
  import ign_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pulseIn,
  input wire logic fallEdge,
  input wire logic [15:0] minTime,
  output logic edgeSeen,
  output logic [15:0] interval
);
  logic prev_ff;
  logic [6:0] preCnt_ff;
  logic [15:0] usCnt_ff;
  logic [15:0] interval_ff;
  logic edge_ff;
  logic tick;
  logic rawEdge;

  assign tick = (preCnt_ff == 7'(`US_CYCLES - 1));
  assign rawEdge = fallEdge ? (prev_ff & ~pulseIn) : (~prev_ff & pulseIn);
  assign edgeSeen = edge_ff;
  assign interval = interval_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= pulseIn;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_ff <= 7'h00;
    end else if (tick) begin
      preCnt_ff <= 7'h00;
    end else begin
      preCnt_ff <= preCnt_ff + 7'h01;
    end
  end

  // Edges closer than the filter time are treated as noise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      usCnt_ff <= 16'h0000;
      interval_ff <= 16'hFFFF;
      edge_ff <= 1'b0;
    end else begin
      edge_ff <= 1'b0;
      if (rawEdge && usCnt_ff >= minTime) begin
        interval_ff <= usCnt_ff;
        usCnt_ff <= 16'h0000;
        edge_ff <= 1'b1;
      end else if (tick && usCnt_ff != 16'hFFFF) begin
        usCnt_ff <= usCnt_ff + 16'h0001;
      end
    end
  end
endmodule

// file: sim/ign_monitor.sv
/* Port checker for the ignition controller.
   Assumes binding to the controller top; one clock domain. */
`timescale 1ns/10ps
module ign_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic camPositionPulse,
  input wire logic [7:0] throttleAngle,
  input wire logic sparkTiming,
  input wire logic hostSpark,
  input wire logic hostDwell,
  input wire logic sparkOut,
  input wire logic dwellOut,
  input wire logic overrideActive,
  input wire logic runMode,
  input wire logic cylOneSync
);
  // ========================================
  // Cycles since a pulse, throttle or write
  logic [3:0] quiet_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      quiet_ff <= 4'h0;
    end else if ($changed(camPositionPulse) || $changed(throttleAngle) ||
        (psel && penable && pwrite)) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hF) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_ovOff;
    $past(reset_n) && !overrideActive && !$past(overrideActive);
  endsequence
  sequence s_ovOn;
    $past(reset_n) && overrideActive && $past(overrideActive);
  endsequence
  a_host_spark: assert property (
    s_ovOff |-> sparkOut == $past(hostSpark)) else $error("spark pass");
  a_host_dwell: assert property (
    s_ovOff |-> dwellOut == $past(hostDwell)) else $error("dwell pass");
  a_own_dwell: assert property (
    s_ovOn |-> dwellOut == $past(sparkTiming)) else $error("own dwell");
  a_sync_single: assert property (
    cylOneSync |=> !cylOneSync) else $error("sync too long");
  a_sync_cause: assert property (
    cylOneSync |-> quiet_ff <= 4'h8) else $error("sync without pulse");
  a_mode_cause: assert property (
    $changed(runMode) |-> quiet_ff <= 4'h8) else $error("mode moved");
  a_ov_cause: assert property (
    $changed(overrideActive) |-> quiet_ff <= 4'h8) else $error("ov moved");
  a_err_access: assert property (
    pslverr |-> psel && penable) else $error("pslverr outside access");
endmodule

bind ignition_mode_override_control ign_monitor ign_monitor_inst (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pslverr(pslverr), .camPositionPulse(camPositionPulse),
  .throttleAngle(throttleAngle), .sparkTiming(sparkTiming),
  .hostSpark(hostSpark), .hostDwell(hostDwell), .sparkOut(sparkOut),
  .dwellOut(dwellOut), .overrideActive(overrideActive),
  .runMode(runMode), .cylOneSync(cylOneSync));

// file: sim/cam_host_model.sv
/* Far-side model: cam pulses on command, host and spark patterns.
   Assumes fire is a one-cycle strobe from the bench. */
`timescale 1ns/10ps
module cam_host_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic fire,
  output logic camPositionPulse,
  output logic sparkTiming,
  output logic hostSpark,
  output logic hostDwell
);
  // ========================================
  // Pulse stretcher and pattern counter
  logic [8:0] width_ff;
  logic [7:0] pat_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      width_ff <= 9'h000;
    end else if (fire) begin
      width_ff <= 9'h1F4;
    end else if (width_ff != 9'h000) begin
      width_ff <= width_ff - 9'h001;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pat_ff <= 8'h00;
    end else begin
      pat_ff <= pat_ff + 8'h01;
    end
  end
  assign camPositionPulse = (width_ff != 9'h000);
  assign sparkTiming = pat_ff[2];
  assign hostSpark = pat_ff[3] ^ pat_ff[0];
  assign hostDwell = pat_ff[4];
endmodule

// file: sim/ignition_mode_override_control_tb_top.sv
/* Bench for the ignition controller: APB set-up, timed cam pulses,
   decisions checked at the ports.
   Assumes package, header, controller, model and checker compiled. */
`timescale 1ns/10ps
`include "ign_cfg.svh"
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin \
  nErrors++; $display("BAD %s exp %h got %h", nm, ex, got); end end

module ignition_mode_override_control_tb_top
  import ign_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fire = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] throttleAngle = 8'h00;
  logic [31:0] prdata, rd;
  logic [15:0] dwellValue;
  logic pready, pslverr, camPositionPulse, sparkTiming, hostSpark;
  logic hostDwell, sparkOut, dwellOut, overrideActive, runMode;
  logic cylOneSync, dwellIsTime, s, sp;
  int nErrors = 0;
  int nTests = 0;
  int syncs = 0;
  longint cyc = 0;
  longint lastEdge = 0;
  logic [11:0] rOff [10] = '{`OFF_CYL, `OFF_FILT, `OFF_SIGANG, `OFF_XSPEED,
    `OFF_HYST, `OFF_IGN, `OFF_DWANG, `OFF_DWTIME, `OFF_OVSPEED, `OFF_OVTHR};
  logic [31:0] rVal [10] = '{32'h8, 32'h32, 32'h1B, 32'h190, 32'h32,
    32'h0, 32'h2D, 32'h1770, 32'hFA0, 32'h1E};
  logic [11:0] cOff [4] = '{`OFF_CYL, `OFF_FILT, `OFF_XSPEED, `OFF_HYST};
  logic [31:0] cVal [4] = '{32'hF, 32'h1, 32'hD6D8, 32'hFA0};
  // Mode config, speed set point, throttle, expected override
  logic [31:0] ovTab [9] = '{32'h0EA60001, 32'h2BF68001, 32'h2C738FF0,
    32'h400001F1, 32'h400001E0, 32'h6BF681F1, 32'h6C7381F0, 32'h6BF681E0,
    32'h3C738001};

  ignition_mode_override_control ignition_mode_override_control_inst (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .camPositionPulse(camPositionPulse),
    .throttleAngle(throttleAngle), .sparkTiming(sparkTiming),
    .hostSpark(hostSpark), .hostDwell(hostDwell), .sparkOut(sparkOut),
    .dwellOut(dwellOut), .overrideActive(overrideActive),
    .runMode(runMode), .cylOneSync(cylOneSync), .dwellValue(dwellValue),
    .dwellIsTime(dwellIsTime));
  cam_host_model cam_host_model_inst (.clock(clock), .reset_n(reset_n),
    .fire(fire), .camPositionPulse(camPositionPulse),
    .sparkTiming(sparkTiming), .hostSpark(hostSpark), .hostDwell(hostDwell));

  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    syncs <= syncs + int'(cylOneSync === 1'b1);
  end

  // ========================================
  // Bus and pulse tasks
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (w >= 20) nErrors++;
    rd = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic camEdge(input int us);
    wait (cyc >= lastEdge + us * 100);
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    lastEdge = cyc;
    repeat (10) @(posedge clock);
  endtask

  task automatic testDone;
    $display("Checks %0d, mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    nErrors++;
    testDone;
  end

  // ========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    foreach (rOff[i]) begin
      apb(1'b0, rOff[i], 32'h0);
      `CHK("reset value", rVal[i], rd)
    end
    foreach (cOff[i]) begin
      apb(1'b1, cOff[i], cVal[i]);
      apb(1'b0, cOff[i], 32'h0);
      `CHK("readback", cVal[i], rd)
    end
    apb(1'b0, 12'h034, 32'h0);
    `CHK("unmapped", 33'h100000000, {s, rd})
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, `OFF_IGN, 32'(t));
      repeat (3) @(posedge clock);
      `CHK("dwell", t == 0 ? 16'h2D : t == 1 ? 16'h1770 : 16'h0, dwellValue)
      `CHK("dwellIsTime", t == 1, dwellIsTime)
    end
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, `OFF_MODCFG, v ? 32'h8 : 32'h0);
      repeat (8) begin
        @(negedge clock);
        sp = sparkTiming;
        @(negedge clock);
        `CHK("sparkOut", sp ^ v[0], sparkOut)
      end
    end
    apb(1'b1, `OFF_MODCFG, 32'h0);
    // First interval short enough that the next one is not a signature
    camEdge(180);
    `CHK("runMode", 1'b0, runMode)
    camEdge(130);
    `CHK("runMode", 1'b1, runMode)
    camEdge(150);
    `CHK("runMode", 1'b1, runMode)
    camEdge(160);
    `CHK("runMode", 1'b0, runMode)
    `CHK("syncs", 0, syncs)
    apb(1'b1, `OFF_OVTHR, 32'h1E);
    foreach (ovTab[i]) begin
      apb(1'b1, `OFF_OVSPEED, {16'h0, ovTab[i][27:12]});
      apb(1'b1, `OFF_MODCFG, {28'h0, ovTab[i][31:28]});
      throttleAngle <= ovTab[i][11:4];
      repeat (6) @(posedge clock);
      `CHK("override", ovTab[i][0], overrideActive)
    end
    camEdge(40);
    `CHK("syncs", 1, syncs)
    testDone;
  end
endmodule
